/* File: logic/flash_prot_pkg.sv */
// Shared constants of the flash error-protection block.
// Assumes a 32-bit plain register port with byte offsets in the low address bits.
package flash_prot_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00; // Command-issuing area
	localparam logic [7:0] OFF_START = 8'h04; // Command start address
	localparam logic [7:0] OFF_MODE = 8'h08; // Program/erase mode select
	localparam logic [7:0] OFF_STATUS = 8'h0c; // Error flags and ready
	localparam logic [7:0] OFF_STARTUP = 8'h10; // Start-up area control
	localparam logic [7:0] OFF_CFGDATA = 8'h14; // Staged configuration word
	localparam logic [7:0] OFF_WINDOW = 8'h18; // Active access window
	localparam logic [7:0] OFF_WEPROT = 8'h1c; // Write/erase protect setting
	localparam logic [7:0] OFF_ACCESS = 8'h20; // Access status
	localparam logic [7:0] OFF_MAP = 8'h24; // Start-up mapping view
	// Command codes
	typedef enum logic [3:0] {
		CMD_PROGRAM = 4'h1,
		CMD_ERASE1 = 4'h2,
		CMD_ERASE2 = 4'h3,
		CMD_BLANK = 4'h4,
		CMD_CONFIG_SET = 4'h5,
		CMD_STATUS_CLEAR = 4'h6,
		CMD_FORCED_STOP = 4'h7,
		CMD_SUSPEND = 4'h8,
		CMD_RESUME = 4'h9
	} cmd_t;
	// Program/erase modes
	typedef enum logic [1:0] {
		MODE_READ = 2'h0,
		MODE_CODE_PE = 2'h1,
		MODE_DATA_PE = 2'h2,
		MODE_BAD = 2'h3
	} pe_mode_t;
	// Array operation states
	typedef enum logic [1:0] {
		OP_IDLE = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_ERASE = 2'h2
	} op_t;
	// Error flag positions in the status register
	localparam int ERR_ILLEGAL = 0;
	localparam int ERR_MODE = 1;
	localparam int ERR_SECURITY = 2;
	localparam int ERR_OTHER = 3;
	localparam int ERR_LOCK = 4;
	localparam int ERR_ERASE = 5;
	localparam int ERR_PROGRAM = 6;
	localparam int ERR_WEP = 7;
	localparam int ERR_W = 8;
	localparam int ST_READY = 15;
	// Access status positions
	localparam int AS_DATA_FLASH_ACCESS_VIOLATION_FLAG = 3;
	localparam int AS_CODE_FLASH_ACCESS_ERROR_FLAG = 4;
	localparam int AS_LOCKED = 7;
	// Mode register fields
	localparam int MODE_SERIAL_BIT = 2;
	localparam int MODE_AUTH_FAIL_BIT = 3;
	// Start-up control and configuration fields
	localparam int SU_SWAP_BIT = 0;
	localparam int SU_PROTECT_BIT = 1;
	localparam int CFG_SWAP_BIT = 31;
	localparam int AW_START_LSB = 0;
	localparam int AW_END_LSB = 16;
	localparam int AW_W = 11;
	// Address layout
	localparam int ADDR_W = 24;
	localparam int BLK_LSB = 13;
	localparam int DATA_SPACE_BIT = 23;
	localparam int STARTUP_BYTES = 8192;
	localparam int STARTUP_LSB = $clog2(STARTUP_BYTES);
	// Reset values
	localparam logic SWAP_RST = 1'b1;
	localparam logic PROTECT_RST = 1'b1;
	localparam logic WEPROT_RST = 1'b1;
	// Longest code-flash program processing, flash-clock cycles
	localparam int PROG_MAX_CYC = 90;
	// Block number of an address
	function automatic logic [AW_W-1:0] block_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:BLK_LSB];
	endfunction : block_of
endpackage : flash_prot_pkg

/* File: logic/flash_area_check.sv */
// Address classifier for flash commands.
// Assumes a stable start address and window settings from the caller's flops.
`timescale 1ns/1ns
`default_nettype none
module flash_area_check #(
	parameter logic [23:0] USER_BYTES = 24'h100000, // Mapped user area size
	parameter logic [23:0] DATA_BYTES = 24'h002000 // Mapped data area size
) (
	input wire logic [23:0] addr_in, // Command start address
	input wire logic [10:0] aw_start_in, // Window first block
	input wire logic [10:0] aw_end_in, // Block after window
	input wire logic susp_valid_in, // Erase suspended
	input wire logic [10:0] susp_block_in, // Suspended erase block
	output logic data_space_out, // Address in data flash
	output logic user_reserved_out, // Unmapped user address
	output logic data_reserved_out, // Unmapped data address
	output logic aw_protected_out, // Outside access window
	output logic in_susp_out // Hits suspended erase block
);
	logic [22:0] offset; // Offset inside the space
	logic [10:0] blk; // Block of the address

	// Classification of the start address
	always_comb begin
		offset = addr_in[flash_prot_pkg::DATA_SPACE_BIT-1:0];
		blk = flash_prot_pkg::block_of(addr_in);
		data_space_out = addr_in[flash_prot_pkg::DATA_SPACE_BIT];
		user_reserved_out = !data_space_out && ({1'b0, offset} >= USER_BYTES);
		data_reserved_out = data_space_out && ({1'b0, offset} >= DATA_BYTES);
		// Window applies to the user area only; equal bounds disable it
		aw_protected_out = !data_space_out && (aw_start_in != aw_end_in) &&
			((blk < aw_start_in) || (blk >= aw_end_in));
		in_susp_out = susp_valid_in && (blk == susp_block_in);
	end
endmodule : flash_area_check
`default_nettype wire

/* File: logic/flash_error_protection.sv */
// Error protection and start-up area select of a flash sequencer.
// Assumes one-cycle bus strobes on CLK_IN and an asynchronous array fail pin.
// Contract
// - Window-protected program/erase1: illegal plus lock
// - Program to suspended erase block rejected
// - Erase failure sets erase error only
// - Program failure sets program error only
// - Code mode reserved user address: access error
// - Range erase/blank reserved: illegal, lock, violation
// - Serial mode after failed authentication: security
// - Config set while unprotected-bit zero: security
// - Command area access in read mode: other
// - Command area read in P/E: other
// - Protect violation: protect flag, no lock
// - 8K start-up area mapped by swap
// - Swap zero selects block 1
// - Protect bit freezes start-up selection
// - Code program at most 90 cycles
// - Lock error enters command-locked state
// - Status clear or stop releases lock
// - Locked command sets only lock error (in read mode the code also sets the other error)
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module flash_error_protection #(
	parameter int PROG_CYCLES = 90, // Code-flash program time
	parameter int ERASE_CYCLES = 32, // Erase and data program time
	parameter logic [23:0] USER_BYTES = 24'h100000, // User area size
	parameter logic [23:0] DATA_BYTES = 24'h002000 // Data area size
) (
	input wire logic CLK_IN, // Flash clock, 10 MHz
	input wire logic RSTN_IN, // Synchronous reset, low
	input wire logic [7:0] ADDR_IN, // Register byte offset
	input wire logic [31:0] WDATA_IN, // Write data
	input wire logic WR_IN, // Write strobe
	input wire logic RD_IN, // Read strobe
	input wire logic [23:0] FETCH_ADDR_IN, // Fetch address to map
	input wire logic ARRAY_FAIL_IN, // Array failure pin
	output logic [31:0] RDATA_OUT, // Read data, next cycle
	output logic READY_OUT, // Sequencer ready
	output logic LOCKED_OUT, // Command-locked state
	output logic [23:0] MAPPED_ADDR_OUT // Physical fetch address
);
	// Counts above 8 bits cannot be held
	if (PROG_CYCLES < 1 || PROG_CYCLES > flash_prot_pkg::PROG_MAX_CYC) begin : g_bad_prog
		$error("PROG_CYCLES out of range");
	end
	if (ERASE_CYCLES < 1 || ERASE_CYCLES > 255) begin : g_bad_erase
		$error("ERASE_CYCLES out of range");
	end

	logic fail_meta; // Fail pin first stage
	logic fail_sync; // Fail pin second stage
	logic [7:0] err; // Error flags
	logic [7:0] next_err; // Next error flags
	logic code_flash_access_error_flag; // Code flash access error
	logic data_flash_access_violation_flag; // Data flash access violation
	logic locked; // Command-locked state
	logic next_locked; // Next locked state
	logic [23:0] start_addr; // Command start address
	flash_prot_pkg::pe_mode_t mode; // Current P/E mode
	logic serial; // Serial programming mode
	logic auth_fail; // ID authentication failed
	logic swap; // Boot swap flag
	logic protect; // Start-up area protect bit
	logic [31:0] cfg_data; // Staged configuration
	logic [10:0] aw_start; // Window first block
	logic [10:0] aw_end; // Block after window
	logic weprot; // Write/erase permitted
	flash_prot_pkg::op_t op; // Running array operation
	logic ready; // Sequencer ready
	logic [7:0] count; // Cycles left in operation
	logic [7:0] susp_count; // Cycles left at suspend
	logic suspended; // Erase suspended
	logic [10:0] op_block; // Block of running operation
	logic [10:0] susp_block; // Block of suspended erase
	logic data_space; // Start address in data flash
	logic user_reserved; // Unmapped user address
	logic data_reserved; // Unmapped data address
	logic aw_protected; // Outside access window
	logic in_susp; // Hits suspended block
	logic cmd_wr; // Write to command area
	logic cmd_rd; // Read of command area
	logic [3:0] opcode; // Issued command code
	logic [7:0] set_err; // Flags raised by command
	logic set_code_flash_access_error_flag; // Raise code access error
	logic set_data_flash_access_violation_flag; // Raise data access violation
	logic do_clear; // Status clear accepted
	logic do_stop; // Forced stop accepted
	logic do_config; // Configuration set accepted
	logic do_suspend; // Suspend accepted
	logic do_resume; // Resume accepted
	flash_prot_pkg::op_t start_op; // Operation to start
	logic [7:0] start_len; // Length of started operation
	logic space_ok; // Address space fits mode
	logic op_fail; // Failure during operation

	// Remap of the start-up area by swap flag
	function automatic logic [23:0] map_fetch(input logic [23:0] a, input logic swp);
		logic [23:0] m;
		m = a;
		if (!swp && (a[23:flash_prot_pkg::STARTUP_LSB+1] == '0)) begin
			m[flash_prot_pkg::STARTUP_LSB] = !a[flash_prot_pkg::STARTUP_LSB];
		end
		return m;
	endfunction : map_fetch

	// Address classification
	flash_area_check #(
		.USER_BYTES(USER_BYTES),
		.DATA_BYTES(DATA_BYTES)
	) u_area (
		.addr_in(start_addr),
		.aw_start_in(aw_start),
		.aw_end_in(aw_end),
		.susp_valid_in(suspended),
		.susp_block_in(susp_block),
		.data_space_out(data_space),
		.user_reserved_out(user_reserved),
		.data_reserved_out(data_reserved),
		.aw_protected_out(aw_protected),
		.in_susp_out(in_susp)
	);

	// Two-stage synchroniser for the fail pin
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			fail_meta <= 1'b0;
			fail_sync <= 1'b0;
		end else begin
			fail_meta <= ARRAY_FAIL_IN;
			fail_sync <= fail_meta;
		end
	end

	// Command evaluation and error classification
	always_comb begin
		cmd_wr = WR_IN && (ADDR_IN == flash_prot_pkg::OFF_CMD);
		cmd_rd = RD_IN && (ADDR_IN == flash_prot_pkg::OFF_CMD);
		opcode = WDATA_IN[3:0];
		set_err = '0;
		set_code_flash_access_error_flag = 1'b0;
		set_data_flash_access_violation_flag = 1'b0;
		do_clear = 1'b0;
		do_stop = 1'b0;
		do_config = 1'b0;
		do_suspend = 1'b0;
		do_resume = 1'b0;
		start_op = flash_prot_pkg::OP_IDLE;
		start_len = '0;
		space_ok = (mode == flash_prot_pkg::MODE_DATA_PE) ? data_space : !data_space;
		if (WR_IN && ADDR_IN == flash_prot_pkg::OFF_MODE && WDATA_IN[1:0] == flash_prot_pkg::MODE_BAD) begin
			// Both P/E modes at once
			set_err[flash_prot_pkg::ERR_MODE] = 1'b1;
			set_err[flash_prot_pkg::ERR_LOCK] = 1'b1;
		end else if (cmd_rd || (cmd_wr && mode == flash_prot_pkg::MODE_READ)) begin
			set_err[flash_prot_pkg::ERR_OTHER] = 1'b1;
			set_err[flash_prot_pkg::ERR_LOCK] = 1'b1;
		end else if (cmd_wr && locked) begin
			if (opcode == flash_prot_pkg::CMD_FORCED_STOP && !code_flash_access_error_flag && !data_flash_access_violation_flag) begin
				do_stop = 1'b1;
			end else if (opcode == flash_prot_pkg::CMD_STATUS_CLEAR && ready && !code_flash_access_error_flag && !data_flash_access_violation_flag) begin
				do_clear = 1'b1;
			end else begin
				set_err[flash_prot_pkg::ERR_LOCK] = 1'b1;
			end
		end else if (cmd_wr && serial && auth_fail) begin
			set_err[flash_prot_pkg::ERR_SECURITY] = 1'b1;
			set_err[flash_prot_pkg::ERR_LOCK] = 1'b1;
		end else if (cmd_wr) begin
			case (opcode)
				flash_prot_pkg::CMD_STATUS_CLEAR: begin
					// Only accepted while ready
					if (ready) begin
						do_clear = 1'b1;
					end else begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end
				end
				flash_prot_pkg::CMD_FORCED_STOP: begin
					do_stop = 1'b1;
				end
				flash_prot_pkg::CMD_CONFIG_SET: begin
					if (!protect) begin
						set_err[flash_prot_pkg::ERR_SECURITY] = 1'b1;
					end else if (!ready) begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end else begin
						do_config = 1'b1;
					end
				end
				flash_prot_pkg::CMD_PROGRAM, flash_prot_pkg::CMD_ERASE1,
				flash_prot_pkg::CMD_ERASE2, flash_prot_pkg::CMD_BLANK: begin
					if (!ready || (suspended && opcode != flash_prot_pkg::CMD_PROGRAM)) begin
						// Busy or erase held in suspend
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end else if (mode == flash_prot_pkg::MODE_CODE_PE && user_reserved) begin
						set_code_flash_access_error_flag = 1'b1;
					end else if (mode == flash_prot_pkg::MODE_DATA_PE && data_reserved) begin
						set_data_flash_access_violation_flag = 1'b1;
						set_err[flash_prot_pkg::ERR_ILLEGAL] =
							(opcode == flash_prot_pkg::CMD_ERASE2) || (opcode == flash_prot_pkg::CMD_BLANK);
					end else if (!space_ok) begin
						// Wrong space for the mode
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end else if (aw_protected && opcode != flash_prot_pkg::CMD_BLANK) begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end else if (opcode == flash_prot_pkg::CMD_PROGRAM && in_susp) begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end else if (!weprot && opcode != flash_prot_pkg::CMD_BLANK) begin
						set_err[flash_prot_pkg::ERR_WEP] = 1'b1;
						set_err[flash_prot_pkg::ERR_PROGRAM] = (opcode == flash_prot_pkg::CMD_PROGRAM);
						set_err[flash_prot_pkg::ERR_ERASE] = (opcode != flash_prot_pkg::CMD_PROGRAM);
					end else if (opcode == flash_prot_pkg::CMD_PROGRAM) begin
						start_op = flash_prot_pkg::OP_PROGRAM;
						start_len = data_space ? 8'(ERASE_CYCLES) : 8'(PROG_CYCLES);
					end else if (opcode != flash_prot_pkg::CMD_BLANK) begin
						start_op = flash_prot_pkg::OP_ERASE;
						start_len = 8'(ERASE_CYCLES);
					end
					// Any refusal except protect violation locks
					set_err[flash_prot_pkg::ERR_LOCK] = set_err[flash_prot_pkg::ERR_ILLEGAL] ||
						set_code_flash_access_error_flag || set_data_flash_access_violation_flag;
				end
				flash_prot_pkg::CMD_SUSPEND: begin
					if (op == flash_prot_pkg::OP_ERASE) begin
						do_suspend = 1'b1;
					end else begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end
				end
				flash_prot_pkg::CMD_RESUME: begin
					if (suspended && ready) begin
						do_resume = 1'b1;
					end else begin
						set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
					end
				end
				default: begin
					// Undefined command code
					set_err[flash_prot_pkg::ERR_ILLEGAL] = 1'b1;
				end
			endcase
			if (set_err[flash_prot_pkg::ERR_ILLEGAL] || set_err[flash_prot_pkg::ERR_SECURITY]) begin
				set_err[flash_prot_pkg::ERR_LOCK] = 1'b1;
			end
		end
	end

	// Flag update, set wins over clear
	always_comb begin
		op_fail = fail_sync && (op != flash_prot_pkg::OP_IDLE);
		next_err = (do_clear || do_stop) ? '0 : err;
		next_err = next_err | set_err;
		next_err[flash_prot_pkg::ERR_ERASE] = next_err[flash_prot_pkg::ERR_ERASE] ||
			(op_fail && op == flash_prot_pkg::OP_ERASE);
		next_err[flash_prot_pkg::ERR_PROGRAM] = next_err[flash_prot_pkg::ERR_PROGRAM] ||
			(op_fail && op == flash_prot_pkg::OP_PROGRAM);
		next_locked = ((do_clear || do_stop) ? 1'b0 : locked) || set_err[flash_prot_pkg::ERR_LOCK];
	end

	// Error and lock flops
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			err <= '0;
			locked <= 1'b0;
			code_flash_access_error_flag <= 1'b0;
			data_flash_access_violation_flag <= 1'b0;
		end else begin
			err <= next_err;
			locked <= next_locked;
			if (WR_IN && ADDR_IN == flash_prot_pkg::OFF_ACCESS) begin
				// Write zero clears an access flag
				code_flash_access_error_flag <= code_flash_access_error_flag && WDATA_IN[flash_prot_pkg::AS_CODE_FLASH_ACCESS_ERROR_FLAG];
				data_flash_access_violation_flag <= data_flash_access_violation_flag && WDATA_IN[flash_prot_pkg::AS_DATA_FLASH_ACCESS_VIOLATION_FLAG];
			end else begin
				code_flash_access_error_flag <= code_flash_access_error_flag || set_code_flash_access_error_flag;
				data_flash_access_violation_flag <= data_flash_access_violation_flag || set_data_flash_access_violation_flag;
			end
		end
	end

	// Array operation sequencer
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			op <= flash_prot_pkg::OP_IDLE;
			ready <= 1'b1;
			count <= '0;
			susp_count <= '0;
			suspended <= 1'b0;
			op_block <= '0;
			susp_block <= '0;
		end else if (do_stop) begin
			// Abort everything
			op <= flash_prot_pkg::OP_IDLE;
			ready <= 1'b1;
			suspended <= 1'b0;
		end else if (start_op != flash_prot_pkg::OP_IDLE) begin
			op <= start_op;
			ready <= 1'b0;
			count <= start_len;
			op_block <= flash_prot_pkg::block_of(start_addr);
		end else if (do_suspend) begin
			op <= flash_prot_pkg::OP_IDLE;
			ready <= 1'b1;
			suspended <= 1'b1;
			susp_count <= count;
			susp_block <= op_block;
		end else if (do_resume) begin
			op <= flash_prot_pkg::OP_ERASE;
			ready <= 1'b0;
			count <= susp_count;
			op_block <= susp_block;
			suspended <= 1'b0;
		end else if (op != flash_prot_pkg::OP_IDLE) begin
			// Count down; failure ends early
			count <= count - 8'h01;
			if (count == 8'h01 || op_fail) begin
				op <= flash_prot_pkg::OP_IDLE;
				ready <= 1'b1;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			start_addr <= '0;
			mode <= flash_prot_pkg::MODE_READ;
			serial <= 1'b0;
			auth_fail <= 1'b0;
			cfg_data <= '0;
			weprot <= flash_prot_pkg::WEPROT_RST;
		end else if (WR_IN) begin
			case (ADDR_IN)
				flash_prot_pkg::OFF_START: begin
					start_addr <= WDATA_IN[23:0];
				end
				flash_prot_pkg::OFF_MODE: begin
					// Invalid mode keeps old one
					if (WDATA_IN[1:0] != flash_prot_pkg::MODE_BAD) begin
						mode <= flash_prot_pkg::pe_mode_t'(WDATA_IN[1:0]);
					end
					serial <= WDATA_IN[flash_prot_pkg::MODE_SERIAL_BIT];
					auth_fail <= WDATA_IN[flash_prot_pkg::MODE_AUTH_FAIL_BIT];
				end
				flash_prot_pkg::OFF_CFGDATA: begin
					cfg_data <= WDATA_IN;
				end
				flash_prot_pkg::OFF_WEPROT: begin
					weprot <= WDATA_IN[0];
				end
				default: begin
					// Other offsets hold nothing here
				end
			endcase
		end
	end

	// Start-up area selection and access window
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			swap <= flash_prot_pkg::SWAP_RST;
			protect <= flash_prot_pkg::PROTECT_RST;
			aw_start <= '0;
			aw_end <= '0;
		end else if (do_config) begin
			aw_start <= cfg_data[flash_prot_pkg::AW_START_LSB +: flash_prot_pkg::AW_W];
			aw_end <= cfg_data[flash_prot_pkg::AW_END_LSB +: flash_prot_pkg::AW_W];
			swap <= cfg_data[flash_prot_pkg::CFG_SWAP_BIT];
		end else if (WR_IN && ADDR_IN == flash_prot_pkg::OFF_STARTUP) begin
			if (protect) begin
				swap <= WDATA_IN[flash_prot_pkg::SU_SWAP_BIT];
			end
			protect <= protect && WDATA_IN[flash_prot_pkg::SU_PROTECT_BIT];
		end
	end

	// Fetch remap and status outputs
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			MAPPED_ADDR_OUT <= '0;
			READY_OUT <= 1'b1;
			LOCKED_OUT <= 1'b0;
		end else begin
			// swap maps blocks 0 and 1
			MAPPED_ADDR_OUT <= map_fetch(FETCH_ADDR_IN, swap);
			READY_OUT <= ready;
			LOCKED_OUT <= locked;
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			RDATA_OUT <= '0;
		end else begin
			RDATA_OUT <= '0;
			if (RD_IN) begin
				case (ADDR_IN)
					flash_prot_pkg::OFF_START: RDATA_OUT <= {8'h00, start_addr};
					flash_prot_pkg::OFF_MODE: begin
						RDATA_OUT[1:0] <= mode;
						RDATA_OUT[flash_prot_pkg::MODE_SERIAL_BIT] <= serial;
						RDATA_OUT[flash_prot_pkg::MODE_AUTH_FAIL_BIT] <= auth_fail;
					end
					flash_prot_pkg::OFF_STATUS: begin
						RDATA_OUT[flash_prot_pkg::ERR_W-1:0] <= err;
						RDATA_OUT[flash_prot_pkg::ST_READY] <= ready;
					end
					flash_prot_pkg::OFF_STARTUP: begin
						RDATA_OUT[flash_prot_pkg::SU_SWAP_BIT] <= swap;
						RDATA_OUT[flash_prot_pkg::SU_PROTECT_BIT] <= protect;
					end
					flash_prot_pkg::OFF_CFGDATA: RDATA_OUT <= cfg_data;
					flash_prot_pkg::OFF_WINDOW: begin
						RDATA_OUT[flash_prot_pkg::AW_START_LSB +: flash_prot_pkg::AW_W] <= aw_start;
						RDATA_OUT[flash_prot_pkg::AW_END_LSB +: flash_prot_pkg::AW_W] <= aw_end;
					end
					flash_prot_pkg::OFF_WEPROT: RDATA_OUT[0] <= weprot;
					flash_prot_pkg::OFF_ACCESS: begin
						RDATA_OUT[flash_prot_pkg::AS_CODE_FLASH_ACCESS_ERROR_FLAG] <= code_flash_access_error_flag;
						RDATA_OUT[flash_prot_pkg::AS_DATA_FLASH_ACCESS_VIOLATION_FLAG] <= data_flash_access_violation_flag;
						RDATA_OUT[flash_prot_pkg::AS_LOCKED] <= locked;
					end
					flash_prot_pkg::OFF_MAP: RDATA_OUT[0] <= !swap;
					default: RDATA_OUT <= '0;
				endcase
			end
		end
	end
endmodule : flash_error_protection
`default_nettype wire

/* File: tb/fep_checker_sva.sv */
// Port-level assertions for the flash error-protection block.
// Assumes it is bound to the top module.
`timescale 1ns/1ns
`default_nettype none
module fep_checker #(parameter int PROG_CYCLES = 90) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [23:0] FETCH_ADDR_IN,
	input wire logic ARRAY_FAIL_IN,
	input wire logic [31:0] RDATA_OUT,
	input wire logic READY_OUT,
	input wire logic LOCKED_OUT,
	input wire logic [23:0] MAPPED_ADDR_OUT
);
	int busy_cnt; // Cycles seen busy
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// Counts the busy stretch
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN || READY_OUT) busy_cnt <= 0;
		else busy_cnt <= busy_cnt + 1;
	end
	sequence s_cmd(c);
		WR_IN && ADDR_IN == flash_prot_pkg::OFF_CMD && WDATA_IN[3:0] == c;
	endsequence
	sequence s_stay_ready;
		##1 READY_OUT ##1 READY_OUT;
	endsequence
	property p_rd_idle; !RD_IN |=> RDATA_OUT == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
	property p_cmd_rd; RD_IN && ADDR_IN == flash_prot_pkg::OFF_CMD |=> RDATA_OUT == 32'h0 ##1 LOCKED_OUT; endproperty
	a_cmd_rd: assert property (p_cmd_rd) else $error("command area read not locked");
	property p_prog_time; busy_cnt <= PROG_CYCLES + 1; endproperty
	a_prog_time: assert property (p_prog_time) else $error("busy too long");
	property p_lock_hold; LOCKED_OUT && !WR_IN && !$past(WR_IN) |=> LOCKED_OUT; endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock left alone");
	property p_release;
		$fell(LOCKED_OUT) |-> $past(WR_IN, 2) && $past(ADDR_IN, 2) == 8'h00 && $past(WDATA_IN[3:1], 2) == 3'h3;
	endproperty
	a_release: assert property (p_release) else $error("lock left without clear");
	property p_lock_cause; $rose(LOCKED_OUT) |-> $past(WR_IN, 2) || $past(RD_IN, 2); endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock without access");
	property p_refuse;
		s_cmd(flash_prot_pkg::CMD_PROGRAM) ##0 (LOCKED_OUT && READY_OUT && !$past(WR_IN)) |-> s_stay_ready;
	endproperty
	a_refuse: assert property (p_refuse) else $error("locked program started");
	property p_map;
		1'b1 |=> MAPPED_ADDR_OUT[23:14] == $past(FETCH_ADDR_IN[23:14]) && MAPPED_ADDR_OUT[12:0] == $past(FETCH_ADDR_IN[12:0]);
	endproperty
	a_map: assert property (p_map) else $error("mapping beyond 8K");
endmodule : fep_checker
bind flash_error_protection fep_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk(.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .FETCH_ADDR_IN(FETCH_ADDR_IN),
	.ARRAY_FAIL_IN(ARRAY_FAIL_IN), .RDATA_OUT(RDATA_OUT), .READY_OUT(READY_OUT), .LOCKED_OUT(LOCKED_OUT),
	.MAPPED_ADDR_OUT(MAPPED_ADDR_OUT));
`default_nettype wire

/* File: tb/array_fail_model.sv */
// Flash array model: reports a failure on request.
// Assumes the ready output marks a running operation.
`timescale 1ns/1ns
`default_nettype none
module array_fail_model (
	input wire logic clk_in,
	input wire logic arm_in,
	input wire logic ready_in,
	output logic fail_out
);
	always @(posedge clk_in) fail_out <= arm_in && !ready_in;
endmodule : array_fail_model
`default_nettype wire

/* File: tb/tb.sv */
// Testbench of the flash error-protection block.
// Assumes the bound checker and the array model.
`timescale 1ns/1ns
`default_nettype none
module tb;
	typedef struct {logic [3:0] m; logic [23:0] ad; logic [3:0] c; logic [7:0] e; logic [1:0] acc;} row_t;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, arm = 1'b0, fail, rdy, lk;
	logic [7:0] a = 8'h00;
	logic [31:0] wd = 32'h0, rv, rdo;
	logic [23:0] fa = 24'h0, ma;
	int err_total = 0, n_compared = 0;
	// Mode, start, command, flags, access flags
	row_t rows[6] = '{'{4'h0, 24'h0, 4'h1, 8'h18, 2'h0}, '{4'h1, 24'h100000, 4'h1, 8'h10, 2'h2},
		'{4'h2, 24'h802000, 4'h1, 8'h10, 2'h1}, '{4'h2, 24'h802000, 4'h3, 8'h11, 2'h1},
		'{4'h2, 24'h802000, 4'h4, 8'h11, 2'h1}, '{4'hd, 24'h0, 4'h1, 8'h14, 2'h0}};
	flash_error_protection #(.PROG_CYCLES(8), .ERASE_CYCLES(8)) u_dut(.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(a),
		.WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .FETCH_ADDR_IN(fa), .ARRAY_FAIL_IN(fail), .RDATA_OUT(rdo),
		.READY_OUT(rdy), .LOCKED_OUT(lk), .MAPPED_ADDR_OUT(ma));
	array_fail_model u_arr(.clk_in(clk), .arm_in(arm), .ready_in(rdy), .fail_out(fail));
	always #50 clk = ~clk;
	task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] ad);
		@(posedge clk);
		a <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdo;
	endtask : bus_rd
	task automatic cmd(input logic [3:0] c);
		bus_wr(8'h00, {28'h0, c});
	endtask : cmd
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic st(input logic [7:0] e);
		bus_rd(8'h0c);
		chk("status", rv & 32'h80ff, {16'h0, 8'h80, e});
	endtask : st
	// Leaves the locked state from code mode
	task automatic clr();
		bus_wr(8'h08, 32'h1);
		bus_wr(8'h20, 32'h0);
		cmd(4'h6);
		st(8'h00);
		chk("unlocked", {31'h0, lk}, 32'h0);
	endtask : clr
	task automatic idle();
		repeat (2) @(posedge clk);
		for (int k = 0; k < 50 && rdy !== 1'b1; k++) @(posedge clk);
		chk("ready", {31'h0, rdy}, 32'h1);
	endtask : idle
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	// Watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		st(8'h00);
		bus_rd(8'h10);
		chk("startup", rv, 32'h3);
		bus_rd(8'h30);
		chk("unmapped", rv, 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			bus_wr(8'h08, {28'h0, rows[i].m});
			bus_wr(8'h04, {8'h0, rows[i].ad});
			cmd(rows[i].c);
			st(rows[i].e);
			bus_rd(8'h20);
			chk("access", {30'h0, rv[4:3]}, {30'h0, rows[i].acc});
			chk("locked", {31'h0, lk}, 32'h1);
			clr();
			$display("row %0d done", i);
		end
		bus_rd(8'h00);
		chk("cmd_read", rv, 32'h0);
		st(8'h18);
		bus_wr(8'h04, 32'h100000);
		cmd(4'h1);
		st(8'h18);
		bus_rd(8'h20);
		chk("access", rv & 32'h18, 32'h0);
		clr();
		$display("lock test done");
		arm <= 1'b1;
		bus_wr(8'h04, 32'h0);
		cmd(4'h1);
		idle();
		st(8'h40);
		chk("locked", {31'h0, lk}, 32'h0);
		clr();
		cmd(4'h2);
		idle();
		st(8'h20);
		arm <= 1'b0;
		clr();
		bus_wr(8'h1c, 32'h0);
		cmd(4'h1);
		idle();
		st(8'hc0);
		bus_wr(8'h1c, 32'h1);
		clr();
		$display("failure test done");
		bus_wr(8'h14, 32'h80020001);
		cmd(4'h5);
		idle();
		cmd(4'h1);
		st(8'h11);
		clr();
		bus_wr(8'h10, 32'h2);
		fa <= 24'h000100;
		bus_rd(8'h24);
		chk("swapped", rv, 32'h1);
		chk("mapped", {8'h0, ma}, 32'h002100);
		bus_wr(8'h10, 32'h0);
		bus_wr(8'h10, 32'h1);
		bus_rd(8'h10);
		chk("startup", rv, 32'h0);
		cmd(4'h5);
		st(8'h14);
		clr();
		$display("start-up test done");
		fa <= 24'h800000;
		bus_wr(8'h04, 32'h2000);
		cmd(4'h2);
		cmd(4'h8);
		cmd(4'h1);
		st(8'h11);
		chk("fetch", {8'h0, ma}, 32'h800000);
		cmd(4'h7);
		st(8'h00);
		chk("unlocked", {31'h0, lk}, 32'h0);
		bus_wr(8'h08, 32'h3);
		st(8'h12);
		$display("suspend test done");
		complete_run();
	end
endmodule : tb
`default_nettype wire
